/* ctr_pkg.sv */
package ctr_pkg;

  // register map, byte addresses on the 8-bit register port
  localparam logic [15:0] CTR_CSR_ADDR = 16'h0008;
  localparam logic [15:0] CTR_CNT_ADDR = 16'h0009;
  localparam logic [15:0] CTR_WDOG_SVC_ADDR = 16'hFFF0;

  // values after reset
  localparam logic [7:0] CTR_CSR_RST = 8'h03;
  localparam logic [7:0] CTR_CNT_RST = 8'h00;
  localparam logic [1:0] CTR_RATE_SEL_RST = 2'h3;

  // chain layout: prescaler, head counter, four stages, three rti stages
  localparam int CTR_PRESCALE_W = 2;
  localparam int CTR_HEAD_W = 8;
  localparam int CTR_HEAD_LSB = CTR_PRESCALE_W;
  localparam int CTR_HEAD_MSB = CTR_HEAD_LSB + CTR_HEAD_W - 1;
  localparam int CTR_RTI_BASE_W = 14;
  localparam int CTR_CHAIN_W = 17;
  localparam logic [1:0] CTR_PRESCALE_LAST = 2'h3;

  // power-on delay in bus clocks
  localparam logic [11:0] CTR_POR_DELAY_CYC = 12'hFE0;
  localparam logic [2:0] CTR_WDOG_LAST = 3'h7;

  // bit 0 of the watchdog service write must be zero
  localparam int CTR_WDOG_SVC_BIT = 0;

  typedef struct packed {
    logic ovf_flag;
    logic rt_flag;
    logic ovf_en;
    logic rt_en;
    logic ovf_clr;
    logic rt_clr;
    logic [1:0] rate_sel;
  } ctr_csr_t;

  typedef enum logic [0:0] {
    CTR_POR = 1'b0,
    CTR_RUN = 1'b1
  } ctr_state_t;

endpackage

/* ctr_core_timer.sv */
// The strobed register port was decided locally.
`timescale 1ns/100ps
// What this block does
// - bus clock divided by four advances the 8-bit head counter
// - count register is read-only and returns the live head count
// - overflow flag sets when head counter wraps, every 1024 clocks
// - interrupt while overflow flag and enable set and cpu mask clear
// - writing one to the overflow clear position clears the flag
// - writing one to the overflow flag bit leaves it unchanged
// - four further stages give bus clock divided by 16384
// - rate select 0..3 gives periods of 2^14..2^17 clocks
// - periodic flag sets on tap event; interrupt with enable, mask clear
// - periodic flag cleared by writing one to its clear position or reset
// - reset sets both rate select bits to one
// - periodic output divided by eight clocks the watchdog stage
// - power-on clears chain, counts delay, clears again and releases
// - external reset clears the whole chain
// - reset forces the count register to zero
// - zero written to bit 0 of service address clears the watchdog
module ctr_core_timer
  import ctr_pkg::*;
#(
  parameter bit WDOG_EN = 1'b1
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ext_reset_n,
  input wire logic cpu_irq_mask,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  output logic timer_irq,
  output logic reset_req
);

  ////////////////////////////////////////////////////////////////////
  logic ext_meta_r;
  logic ext_rst_r;
  ctr_state_t state_r;
  logic [11:0] por_cnt_r;
  logic [CTR_CHAIN_W-1:0] chain_r;
  logic [2:0] wdog_cnt_r;
  logic wdog_to_r;
  logic ovf_flag_r;
  logic rt_flag_r;
  logic ovf_en_r;
  logic rt_en_r;
  logic [1:0] rate_sel_r;
  logic [7:0] rdata_r;
  logic irq_r;
  logic reset_req_r;

  logic run;
  logic por_done;
  logic hold_rst;
  logic chain_clr;
  logic ovf_evt;
  logic rti_evt;
  logic csr_wr;
  logic svc_wr;
  ctr_csr_t csr_w;
  ctr_csr_t csr_rd;
  logic [CTR_CHAIN_W-1:0] tap_mask;

  assign run = (state_r == CTR_RUN);
  assign por_done = !run && (por_cnt_r == CTR_POR_DELAY_CYC - 12'h001);
  assign hold_rst = srst || ext_rst_r || wdog_to_r || !run;
  assign chain_clr = srst || ext_rst_r || wdog_to_r || por_done;
  assign csr_w = ctr_csr_t'(bus_wdata);
  assign csr_wr = bus_wr && (bus_addr == CTR_CSR_ADDR);
  assign svc_wr = bus_wr && (bus_addr == CTR_WDOG_SVC_ADDR) &&
                  !bus_wdata[CTR_WDOG_SVC_BIT];

  // head counter wraps when prescaler and head are all ones
  assign ovf_evt = !hold_rst && (&chain_r[CTR_HEAD_MSB:0]);

  // selected tap wraps: low 14 bits all ones plus the chosen upper bits
  assign rti_evt = !hold_rst && (&chain_r[CTR_RTI_BASE_W-1:0]) &&
                   (rate_sel_r == 2'h0 || chain_r[CTR_RTI_BASE_W]) &&
                   (!rate_sel_r[1] || chain_r[CTR_RTI_BASE_W+1]) &&
                   (rate_sel_r != 2'h3 || chain_r[CTR_RTI_BASE_W+2]);

  // chain bits below the selected tap, used by the tap checks
  assign tap_mask = (17'h00001 << (CTR_RTI_BASE_W + int'(rate_sel_r))) -
                    17'h00001;

  ////////////////////////////////////////////////////////////////////
  // external reset pin synchroniser
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ext_meta_r <= 1'b0;
      ext_rst_r <= 1'b0;
    end else begin
      ext_meta_r <= !ext_reset_n;
      ext_rst_r <= ext_meta_r;
    end
  end

  // power-on sequencing
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_r <= CTR_POR;
      por_cnt_r <= 12'h000;
    end else begin
      case (state_r)
        CTR_POR: begin
          por_cnt_r <= por_cnt_r + 12'h001;
          if (por_done) begin
            state_r <= CTR_RUN;
          end
        end
        CTR_RUN: begin
          por_cnt_r <= 12'h000;
        end
        default: begin
          state_r <= CTR_POR;
        end
      endcase
    end
  end

  // the divider chain counts during power-on as well
  always_ff @(posedge clk_sys) begin
    if (chain_clr) begin
      chain_r <= '0;
    end else begin
      chain_r <= chain_r + 17'h00001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // watchdog: final divide-by-eight, service clears only this stage
  always_ff @(posedge clk_sys) begin
    if (hold_rst) begin
      wdog_cnt_r <= 3'h0;
      wdog_to_r <= 1'b0;
    end else begin
      wdog_to_r <= WDOG_EN && rti_evt && !svc_wr &&
                   (wdog_cnt_r == CTR_WDOG_LAST);
      if (svc_wr) begin
        wdog_cnt_r <= 3'h0;
      end else if (rti_evt) begin
        wdog_cnt_r <= wdog_cnt_r + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // status flags: events win over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (hold_rst) begin
      ovf_flag_r <= 1'b0;
    end else if (ovf_evt) begin
      ovf_flag_r <= 1'b1;
    end else if (csr_wr && csr_w.ovf_clr) begin
      ovf_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (hold_rst) begin
      rt_flag_r <= 1'b0;
    end else if (rti_evt) begin
      rt_flag_r <= 1'b1;
    end else if (csr_wr && csr_w.rt_clr) begin
      rt_flag_r <= 1'b0;
    end
  end

  // control bits
  always_ff @(posedge clk_sys) begin
    if (hold_rst) begin
      ovf_en_r <= 1'b0;
      rt_en_r <= 1'b0;
      rate_sel_r <= CTR_RATE_SEL_RST;
    end else if (csr_wr) begin
      ovf_en_r <= csr_w.ovf_en;
      rt_en_r <= csr_w.rt_en;
      rate_sel_r <= csr_w.rate_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // one interrupt line for both sources
  always_ff @(posedge clk_sys) begin
    if (hold_rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= !cpu_irq_mask &&
               ((ovf_flag_r && ovf_en_r) || (rt_flag_r && rt_en_r));
    end
  end

  always_ff @(posedge clk_sys) begin
    reset_req_r <= srst || !run || ext_rst_r || wdog_to_r;
  end

  ////////////////////////////////////////////////////////////////////
  // register reads, data one cycle after the strobe
  always_comb begin
    csr_rd = '0;
    csr_rd.ovf_flag = ovf_flag_r;
    csr_rd.rt_flag = rt_flag_r;
    csr_rd.ovf_en = ovf_en_r;
    csr_rd.rt_en = rt_en_r;
    csr_rd.rate_sel = rate_sel_r;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_r <= CTR_CNT_RST;
    end else if (bus_rd && bus_addr == CTR_CSR_ADDR) begin
      rdata_r <= csr_rd;
    end else if (bus_rd && bus_addr == CTR_CNT_ADDR) begin
      rdata_r <= chain_r[CTR_HEAD_MSB:CTR_HEAD_LSB];
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign bus_rdata = rdata_r;
  assign timer_irq = irq_r;
  assign reset_req = reset_req_r;

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  property p_prescale;
    (!chain_clr && chain_r[1:0] == CTR_PRESCALE_LAST && !(&chain_r[9:2]))
      |=> (chain_r[9:2] == $past(chain_r[9:2]) + 8'h01);
  endproperty
  a_prescale: assert property (p_prescale)
    else $error("head counter did not advance after four clocks");

  property p_cnt_read;
    (bus_rd && bus_addr == CTR_CNT_ADDR)
      |=> (bus_rdata == $past(chain_r[9:2]));
  endproperty
  a_cnt_read: assert property (p_cnt_read)
    else $error("count read differs from live counter");

  property p_ovf_set;
    ovf_evt |=> (ovf_flag_r && chain_r[9:0] == 10'h000);
  endproperty
  a_ovf_set: assert property (p_ovf_set)
    else $error("overflow flag not set on wrap");

  property p_irq;
    (ovf_flag_r && ovf_en_r && !cpu_irq_mask && !hold_rst) |=> irq_r;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt missing for enabled overflow");

  property p_ovf_clr;
    (csr_wr && csr_w.ovf_clr && !ovf_evt && !hold_rst) |=> !ovf_flag_r;
  endproperty
  a_ovf_clr: assert property (p_ovf_clr)
    else $error("overflow flag not cleared");

  property p_ovf_noset;
    (csr_wr && !ovf_flag_r && !ovf_evt) |=> !ovf_flag_r;
  endproperty
  a_ovf_noset: assert property (p_ovf_noset)
    else $error("software set the overflow flag");

  property p_rt_set;
    rti_evt |=> (rt_flag_r && chain_r[13:0] == 14'h0000);
  endproperty
  a_rt_set: assert property (p_rt_set)
    else $error("periodic flag not set on tap");

  property p_wdog;
    wdog_to_r |-> ($past(wdog_cnt_r) == 3'h7 && $past(rti_evt));
  endproperty
  a_wdog: assert property (p_wdog)
    else $error("watchdog timeout without eighth tap");

  property p_por;
    por_done |=> (run && chain_r == '0 && rate_sel_r == 2'h3);
  endproperty
  a_por: assert property (p_por)
    else $error("power-on release did not clear chain");

  property p_ext;
    ext_rst_r |=> (chain_r == '0 && !ovf_en_r && reset_req);
  endproperty
  a_ext: assert property (p_ext)
    else $error("external reset did not clear chain");

  property p_ovf_rst;
    hold_rst |=> (!ovf_flag_r && !ovf_en_r);
  endproperty
  a_ovf_rst: assert property (p_ovf_rst)
    else $error("reset left overflow flag or enable set");

  property p_rate_rst;
    hold_rst |=> (rate_sel_r == CTR_RATE_SEL_RST && !rt_flag_r);
  endproperty
  a_rate_rst: assert property (p_rate_rst)
    else $error("reset left rate select or periodic flag wrong");

  property p_rt_clr;
    (csr_wr && csr_w.rt_clr && !rti_evt && !hold_rst) |=> !rt_flag_r;
  endproperty
  a_rt_clr: assert property (p_rt_clr)
    else $error("periodic flag not cleared");

  property p_rt_noset;
    (csr_wr && !rt_flag_r && !rti_evt) |=> !rt_flag_r;
  endproperty
  a_rt_noset: assert property (p_rt_noset)
    else $error("software set the periodic flag");

  property p_rt_irq;
    (rt_flag_r && rt_en_r && !cpu_irq_mask && !hold_rst) |=> irq_r;
  endproperty
  a_rt_irq: assert property (p_rt_irq)
    else $error("interrupt missing for enabled periodic flag");

  property p_irq_masked;
    cpu_irq_mask |=> !irq_r;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("interrupt raised while cpu mask set");

  property p_svc;
    (svc_wr && !hold_rst) |=> (wdog_cnt_r == 3'h0 && !wdog_to_r);
  endproperty
  a_svc: assert property (p_svc)
    else $error("watchdog service did not clear the last stage");

  property p_chain_step;
    !chain_clr |=> (chain_r == $past(chain_r) + 17'h00001);
  endproperty
  a_chain_step: assert property (p_chain_step)
    else $error("chain did not advance by one");

  property p_ovf_rise;
    $rose(ovf_flag_r) |-> ($past(chain_r[CTR_HEAD_MSB:0]) == 10'h3FF);
  endproperty
  a_ovf_rise: assert property (p_ovf_rise)
    else $error("overflow flag set away from the wrap");

  property p_rt_rise;
    $rose(rt_flag_r) |-> ($past(chain_r[CTR_RTI_BASE_W-1:0]) == 14'h3FFF);
  endproperty
  a_rt_rise: assert property (p_rt_rise)
    else $error("periodic flag set away from the base wrap");

  property p_tap_evt;
    rti_evt |-> (((chain_r + 17'h00001) & tap_mask) == 17'h00000);
  endproperty
  a_tap_evt: assert property (p_tap_evt)
    else $error("periodic event away from the selected tap");

  property p_tap_hit;
    (!hold_rst && ((chain_r + 17'h00001) & tap_mask) == 17'h00000)
      |-> rti_evt;
  endproperty
  a_tap_hit: assert property (p_tap_hit)
    else $error("selected tap wrapped without a periodic event");

  property p_wdog_hold;
    (!rti_evt && !svc_wr && !hold_rst)
      |=> (wdog_cnt_r == $past(wdog_cnt_r));
  endproperty
  a_wdog_hold: assert property (p_wdog_hold)
    else $error("watchdog stage moved without a periodic event");

  property p_rdata_idle;
    !bus_rd |=> (bus_rdata == 8'h00);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside a read");

  c_ovf_irq: cover property (ovf_evt ##1 ovf_flag_r ##1 irq_r);
  c_rt: cover property (rti_evt && rate_sel_r == 2'h0);
  c_wdog: cover property (wdog_to_r ##1 reset_req);
  c_svc: cover property (svc_wr && wdog_cnt_r != 3'h0);
  c_rate1: cover property (rti_evt && rate_sel_r == 2'h1);

endmodule // ctr_core_timer

/* core_timer_rti_tb_top.sv */
`timescale 1ns/100ps
module core_timer_rti_tb_top;
  import ctr_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic ext_reset_n = 1'b1;
  logic cpu_irq_mask = 1'b0;
  logic [15:0] bus_addr = 16'h0000;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [7:0] bus_rdata;
  logic timer_irq;
  logic reset_req;
  int errors = 0;
  int compares = 0;
  logic [7:0] v;
  logic [7:0] a;
  int n0;
  int n1;

  always #2.5 clk_sys = ~clk_sys;

  ctr_core_timer u_dut (
    .clk_sys(clk_sys),
    .srst(srst),
    .ext_reset_n(ext_reset_n),
    .cpu_irq_mask(cpu_irq_mask),
    .bus_addr(bus_addr),
    .bus_wdata(bus_wdata),
    .bus_wr(bus_wr),
    .bus_rd(bus_rd),
    .bus_rdata(bus_rdata),
    .timer_irq(timer_irq),
    .reset_req(reset_req)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] ad, input logic [7:0] d);
    @(posedge clk_sys);
    bus_wr <= 1'b1;
    bus_addr <= ad;
    bus_wdata <= d;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
  endtask

  // read data is taken in the single cycle after the strobe
  task automatic rd(input logic [15:0] ad, output logic [7:0] d);
    @(posedge clk_sys);
    bus_rd <= 1'b1;
    bus_addr <= ad;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    #1;
    d = bus_rdata;
  endtask

  // counts edges until the interrupt line reaches lvl
  task automatic wait_irq(input logic lvl, input int bound, output int n);
    n = 0;
    #1;
    while (timer_irq !== lvl) begin
      @(posedge clk_sys);
      #1;
      n++;
      if (n > bound) begin
        errors++;
        $display("BAD timer_irq exp %b seen %b", lvl, timer_irq);
        complete_run();
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    #1;
    chk("reset_req_por", reset_req, 8'h01);
    for (n0 = 0; reset_req !== 1'b0 && n0 < 4200; n0++) begin
      @(posedge clk_sys);
      #1;
    end
    chk("por_delay", n0 > 4060 && n0 < 4070, 8'h01);
    rd(CTR_CNT_ADDR, v);
    chk("count_rst", v, CTR_CNT_RST);
    rd(CTR_CSR_ADDR, v);
    chk("csr_rst", v, CTR_CSR_RST);
    $display("test reset done");
    // a write must not disturb the count; 40 clocks advance it by 10
    rd(CTR_CNT_ADDR, a);
    wr(CTR_CNT_ADDR, 8'hFF);
    repeat (36) @(posedge clk_sys);
    rd(CTR_CNT_ADDR, v);
    chk("count_live", v, a + 8'h0A);
    rd(16'h0040, v);
    chk("unmapped", v, 8'h00);
    wr(CTR_WDOG_SVC_ADDR, 8'h00);
    rd(CTR_WDOG_SVC_ADDR, v);
    chk("svc_read", v, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(CTR_WDOG_SVC_ADDR, 8'h00);
      wr(CTR_CSR_ADDR, 8'(i));
      rd(CTR_CSR_ADDR, v);
      chk("rate_sel", {2'b00, v[5:0]}, 8'(i));
    end
    $display("test count done");
    wr(CTR_WDOG_SVC_ADDR, 8'h00);
    wr(CTR_CSR_ADDR, 8'h00);
    repeat (1100) @(posedge clk_sys);
    rd(CTR_CSR_ADDR, v);
    chk("ovf_no_en", v[7], 8'h01);
    chk("irq_no_en", timer_irq, 8'h00);
    wr(CTR_CSR_ADDR, 8'h28);
    wait_irq(1'b1, 1100, n1);
    rd(CTR_CSR_ADDR, v);
    chk("ovf_set", v[7], 8'h01);
    @(posedge clk_sys);
    cpu_irq_mask <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("irq_masked", timer_irq, 8'h00);
    @(posedge clk_sys);
    cpu_irq_mask <= 1'b0;
    wr(CTR_CSR_ADDR, 8'hA0);
    rd(CTR_CSR_ADDR, v);
    chk("ovf_write_one", v[7], 8'h01);
    wait_irq(1'b1, 4, n1);
    wr(CTR_CSR_ADDR, 8'h28);
    wait_irq(1'b0, 4, n0);
    wait_irq(1'b1, 1100, n1);
    wr(CTR_CSR_ADDR, 8'h28);
    wait_irq(1'b0, 4, n0);
    wait_irq(1'b1, 1100, n1);
    chk("ovf_period", 2 + n0 + n1 == 1024, 8'h01);
    $display("test overflow done");
    wr(CTR_CSR_ADDR, 8'h1C);
    wait_irq(1'b0, 4, n0);
    wait_irq(1'b1, 17000, n1);
    rd(CTR_CSR_ADDR, v);
    chk("rt_set", v[6], 8'h01);
    wr(CTR_CSR_ADDR, 8'h14);
    wait_irq(1'b0, 4, n0);
    wait_irq(1'b1, 17000, n1);
    chk("rt_period", 4 + n0 + n1 == 16384, 8'h01);
    $display("test periodic done");
    @(posedge clk_sys);
    ext_reset_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    #1;
    chk("reset_req_ext", reset_req, 8'h01);
    @(posedge clk_sys);
    ext_reset_n <= 1'b1;
    for (n0 = 0; reset_req !== 1'b0 && n0 < 10; n0++) begin
      @(posedge clk_sys);
      #1;
    end
    chk("ext_release", n0 < 10, 8'h01);
    rd(CTR_CSR_ADDR, v);
    chk("csr_ext_rst", v, CTR_CSR_RST);
    chk("irq_ext_rst", timer_irq, 8'h00);
    $display("test ext reset done");
    // chain restarts at zero, so the first rate 1 tap comes near 2^15
    wr(CTR_WDOG_SVC_ADDR, 8'h00);
    wr(CTR_CSR_ADDR, 8'h11);
    wait_irq(1'b1, 33000, n1);
    chk("rt_rate1", n1 > 32700 && n1 < 32768, 8'h01);
    $display("test rate done");
    complete_run();
  end
endmodule // core_timer_rti_tb_top
